// ---- shared/ctu_consts.svh ----
/*
  Constants of the counter/timer unit: word bit positions, prescaler
  limits, reset values and the register map of the controller end.
  Assumes it is included by its bare name wherever a value is needed.
*/
// Overview of operation
// - Byte with bit zero set is control
// - Enabled channel requests interrupt at zero count
// - Interrupt enable changes without disturbing settings; here every control word rewrites all settings
// - Mode bit picks timer or counter operation
// - Timer prescaler divides by 16 or 256
// - Edge bit picks active trigger input edge
// - Timer starts automatically or on trigger edge
// - Announced next byte loads the time constant
// - Software reset stops until new constant
// - No counting before a time constant arrives
// - Constant spans 1 to 256, zero means 256
// - Software programs vector when interrupts used
// - Vector byte has bit zero clear
// - Channel fills vector bits two and one
// - Setup bit routes parallel port pins here
`ifndef CTU_CONSTS_SVH
`define CTU_CONSTS_SVH

// Bit positions inside a control word.
`define CTU_BIT_CTRL 0
`define CTU_BIT_SWRST 1
`define CTU_BIT_TCNEXT 2
`define CTU_BIT_TRIG 3
`define CTU_BIT_EDGE 4
`define CTU_BIT_PRE 5
`define CTU_BIT_MODE 6
`define CTU_BIT_IE 7

// Prescaler terminal counts for divide-by-16 and divide-by-256.
`define CTU_PRE16_LIM 8'h0F
`define CTU_PRE256_LIM 8'hFF

// Downcounter value from which the next step reaches zero.
`define CTU_CNT_LAST 8'h01

// Reset values.
`define CTU_TC_RST 8'h00
`define CTU_VEC_RST 5'h00
`define CTU_SETUP_RST 8'h00
`define CTU_MASK_RST 2'h0

// Bit of the system setup register that routes the port pins.
`define CTU_SETUP_PIN 0

// Controller register byte offsets on APB.
`define CTU_OFF_WORD 8'h00
`define CTU_OFF_STAT 8'h04
`define CTU_OFF_MASK 8'h08
`define CTU_OFF_VEC 8'h0C
`define CTU_OFF_SETUP 8'h10
`define CTU_OFF_ACK 8'h14

// Sticky status bits of the controller.
`define CTU_ST_REQ 0
`define CTU_ST_VEC 1

`endif

// ---- shared/ctu_pkg.sv ----
/*
  Types shared by the counter/timer unit ends.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ctu_pkg;

  // Channel run state.
  typedef enum logic [1:0] {
    CTU_STOPPED,
    CTU_WAIT_TRIG,
    CTU_RUNNING
  } ctu_state_e;

  typedef logic [7:0] ctu_byte_t;

endpackage

// ---- shared/ctu_link_if.sv ----
/*
  Link between the processor-side controller and the channel.
  Assumes both ends run on the same clock; all strobes last one cycle.
*/
`timescale 1ns/1ps
interface ctu_link_if;
  logic wrStb;
  logic [7:0] wrData;
  logic intAck;
  logic pinRoute;
  logic intReq;
  logic vecValid;
  logic [7:0] vecData;

  // Controller end: writes words and acknowledges interrupts.
  modport host (
    output wrStb,
    output wrData,
    output intAck,
    output pinRoute,
    input intReq,
    input vecValid,
    input vecData
  );

  // Channel end.
  modport dev (
    input wrStb,
    input wrData,
    input intAck,
    input pinRoute,
    output intReq,
    output vecValid,
    output vecData
  );
endinterface // ctu_link_if

// ---- rtl/ctu_prescaler.sv ----
/*
  Prescaler of the timer: a free counter that pulses at its limit.
  Assumes run is low whenever the channel is not timing, which
  restarts the division from zero.
*/
`timescale 1ns/1ps
`include "ctu_consts.svh"
module ctu_prescaler #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic run,
  input wire logic [WIDTH-1:0] limit,
  output logic tick
);
  logic [WIDTH-1:0] cnt_r;

  // The tick is combinational so the downcounter steps in the same edge.
  assign tick = run & (cnt_r == limit);

  // Count while running, wrap at the limit, clear when stopped.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else if (ce) begin
      if (!run || tick) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule // ctu_prescaler

// ---- rtl/ctu_channel.sv ----
/*
  One counter/timer channel: decodes control, time constant and vector
  bytes, runs the downcounter and answers interrupt acknowledges.
  Assumes the controller keeps the byte order of the word protocol and
  that trigger pins are synchronous to mclk.
*/
`timescale 1ns/1ps
`include "ctu_consts.svh"
module ctu_channel (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  ctu_link_if.dev link,
  input wire logic [1:0] chanNum,
  input wire logic trigPin,
  input wire logic pioTrig,
  output logic zcOut,
  output logic pioOut,
  output logic [7:0] countVal
);
  ctu_pkg::ctu_state_e state_r;
  logic expectTc_r;
  logic ie_r;
  logic mode_r;
  logic pre_r;
  logic edge_r;
  logic trig_r;
  logic [7:0] tc_r;
  logic [7:0] cnt_r;
  logic [4:0] vec_r;
  logic trigPrev_r;
  logic intReq_r;
  logic vecValid_r;
  logic [7:0] vecData_r;
  logic zcOut_r;
  logic pioOut_r;
  logic trigSel;
  logic activeEdge;
  logic isTc;
  logic isCtrl;
  logic isVec;
  logic swRst;
  logic preTick;
  logic preRun;
  logic dec;
  logic zero;
  logic ackTake;
  logic [7:0] preLimit;

  // Every output is a flip-flop.
  assign link.intReq = intReq_r;
  assign link.vecValid = vecValid_r;
  assign link.vecData = vecData_r;
  assign zcOut = zcOut_r;
  assign pioOut = pioOut_r;
  assign countVal = cnt_r;

  // The trigger comes from the port pin when the setup bit routes it.
  assign trigSel = link.pinRoute ? pioTrig : trigPin;

  // Edge select: set means rising, clear means falling.
  assign activeEdge = edge_r ? (trigSel & ~trigPrev_r)
                             : (~trigSel & trigPrev_r);

  // Byte classification: an announced byte is always a time constant,
  // even with bit zero set, so the constant may take any value.
  assign isTc = link.wrStb & expectTc_r;
  assign isCtrl = link.wrStb & ~expectTc_r
                  & link.wrData[`CTU_BIT_CTRL];
  assign isVec = link.wrStb & ~expectTc_r
                 & ~link.wrData[`CTU_BIT_CTRL];
  assign swRst = isCtrl & link.wrData[`CTU_BIT_SWRST];

  // Prescaler only runs while timing.
  assign preRun = (state_r == ctu_pkg::CTU_RUNNING) & ~mode_r;
  assign preLimit = pre_r ? `CTU_PRE256_LIM : `CTU_PRE16_LIM;

  ctu_prescaler #(
    .WIDTH(8)
  ) u_pre (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .run(preRun),
    .limit(preLimit),
    .tick(preTick)
  );

  // Counter mode steps on trigger edges, timer mode on prescaler ticks.
  assign dec = (state_r == ctu_pkg::CTU_RUNNING)
               & (mode_r ? activeEdge : preTick);
  assign zero = dec & (cnt_r == `CTU_CNT_LAST);
  assign ackTake = link.intAck & intReq_r;

  // Trigger history for edge detection.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      trigPrev_r <= 1'b0;
    end else if (ce) begin
      trigPrev_r <= trigSel;
    end
  end

  // Channel settings; a control word rewrites them all at once, so the
  // interrupt enable cannot be toggled without rewriting all the others.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ie_r <= 1'b0;
      mode_r <= 1'b0;
      pre_r <= 1'b0;
      edge_r <= 1'b0;
      trig_r <= 1'b0;
    end else if (ce && isCtrl) begin
      ie_r <= link.wrData[`CTU_BIT_IE];
      mode_r <= link.wrData[`CTU_BIT_MODE];
      pre_r <= link.wrData[`CTU_BIT_PRE];
      edge_r <= link.wrData[`CTU_BIT_EDGE];
      trig_r <= link.wrData[`CTU_BIT_TRIG];
    end
  end

  // Announcement flag for the next byte.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      expectTc_r <= 1'b0;
    end else if (ce) begin
      if (isCtrl) begin
        expectTc_r <= link.wrData[`CTU_BIT_TCNEXT];
      end else if (isTc) begin
        expectTc_r <= 1'b0;
      end
    end
  end

  // Stored time constant; used at every reload.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tc_r <= `CTU_TC_RST;
    end else if (ce && isTc) begin
      tc_r <= link.wrData;
    end
  end

  // Vector: only the upper five bits are kept from software.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      vec_r <= `CTU_VEC_RST;
    end else if (ce && isVec) begin
      vec_r <= link.wrData[7:3];
    end
  end

  // Run state. A constant loaded while running only changes the next
  // reload; a stopped channel starts on it, or in triggered timer mode waits for the trigger edge.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ctu_pkg::CTU_STOPPED;
    end else if (ce) begin
      if (swRst) begin
        state_r <= ctu_pkg::CTU_STOPPED;
      end else begin
        case (state_r)
          ctu_pkg::CTU_STOPPED: begin
            if (isTc) begin
              if (!mode_r && trig_r) begin
                state_r <= ctu_pkg::CTU_WAIT_TRIG;
              end else begin
                state_r <= ctu_pkg::CTU_RUNNING;
              end
            end
          end
          ctu_pkg::CTU_WAIT_TRIG: begin
            if (activeEdge) begin
              state_r <= ctu_pkg::CTU_RUNNING;
            end
          end
          ctu_pkg::CTU_RUNNING: begin
            state_r <= ctu_pkg::CTU_RUNNING;
          end
          default: begin
            state_r <= ctu_pkg::CTU_STOPPED;
          end
        endcase
      end
    end
  end

  // Downcounter. A loaded zero wraps through 255 and so counts 256.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= `CTU_TC_RST;
    end else if (ce) begin
      if (isTc && state_r == ctu_pkg::CTU_STOPPED) begin
        cnt_r <= link.wrData;
      end else if (zero) begin
        cnt_r <= tc_r;
      end else if (dec) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end

  // Zero-count pulses; the port pin copy only while routed.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      zcOut_r <= 1'b0;
      pioOut_r <= 1'b0;
    end else if (ce) begin
      zcOut_r <= zero;
      pioOut_r <= zero & link.pinRoute;
    end
  end

  // Interrupt request: a new zero count wins over acknowledge or reset
  // in the same cycle, so no event is lost.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      intReq_r <= 1'b0;
    end else if (ce) begin
      if (zero && ie_r) begin
        intReq_r <= 1'b1;
      end else if (ackTake || swRst) begin
        intReq_r <= 1'b0;
      end
    end
  end

  // Vector answer, one cycle after an acknowledge of a pending request.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      vecValid_r <= 1'b0;
      vecData_r <= 8'h00;
    end else if (ce) begin
      vecValid_r <= ackTake;
      if (ackTake) begin
        vecData_r <= {vec_r, chanNum, 1'b0};
      end
    end
  end
endmodule // ctu_channel

// ---- rtl/ctu_host.sv ----
/*
  Processor-side controller: an APB slave whose registers send bytes
  to the channel, acknowledge interrupts and gather status.
  Assumes an APB master on the same clock and the channel on the link.
*/
`timescale 1ns/1ps
`include "ctu_consts.svh"
module ctu_host (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  ctu_link_if.host link
);
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic irq_r;
  logic wrStb_r;
  ctu_pkg::ctu_byte_t wrData_r;
  logic intAck_r;
  logic [7:0] setup_r;
  logic [1:0] mask_r;
  logic [1:0] status_r;
  logic [7:0] lastVec_r;
  logic reqPrev_r;
  logic acc;
  logic take;
  logic done;
  logic mapped;
  logic rdClr;
  logic [1:0] events;
  logic [31:0] rdMux;

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign link.wrStb = wrStb_r;
  assign link.wrData = wrData_r;
  assign link.intAck = intAck_r;
  assign link.pinRoute = setup_r[`CTU_SETUP_PIN];

  // One wait state: the slave decodes in the first access cycle.
  assign acc = psel & penable;
  assign take = acc & ~pready_r;
  assign done = acc & pready_r;
  assign mapped = (paddr == `CTU_OFF_WORD) || (paddr == `CTU_OFF_STAT)
                  || (paddr == `CTU_OFF_MASK) || (paddr == `CTU_OFF_VEC)
                  || (paddr == `CTU_OFF_SETUP) || (paddr == `CTU_OFF_ACK);

  // Clearing at capture time means no event slips between read and clear.
  assign rdClr = take & ~pwrite & (paddr == `CTU_OFF_STAT);
  assign events = {link.vecValid, link.intReq & ~reqPrev_r};

  // Read data; write-only and unmapped words read as zero.
  always_comb begin
    rdMux = 32'h0000_0000;
    case (paddr)
      `CTU_OFF_STAT: rdMux = {29'h0, link.intReq, status_r};
      `CTU_OFF_MASK: rdMux = {30'h0, mask_r};
      `CTU_OFF_VEC: rdMux = {24'h0, lastVec_r};
      `CTU_OFF_SETUP: rdMux = {24'h0, setup_r};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // APB answer.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else if (ce) begin
      pready_r <= take;
      pslverr_r <= take & ~mapped;
      if (take) begin
        prdata_r <= pwrite ? 32'h0000_0000 : rdMux;
      end
    end
  end

  // Register writes take effect at the completing edge.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      setup_r <= `CTU_SETUP_RST;
      mask_r <= `CTU_MASK_RST;
    end else if (ce && done && pwrite) begin
      if (paddr == `CTU_OFF_SETUP) begin
        setup_r <= pwdata[7:0];
      end
      if (paddr == `CTU_OFF_MASK) begin
        mask_r <= pwdata[1:0];
      end
    end
  end

  // Link strobes: one cycle each, after the completing edge. Software
  // must keep the byte order itself; nothing here checks it.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wrStb_r <= 1'b0;
      wrData_r <= 8'h00;
      intAck_r <= 1'b0;
    end else if (ce) begin
      wrStb_r <= done & pwrite & (paddr == `CTU_OFF_WORD);
      intAck_r <= done & pwrite & (paddr == `CTU_OFF_ACK);
      if (done && pwrite && paddr == `CTU_OFF_WORD) begin
        wrData_r <= pwdata[7:0];
      end
    end
  end

  // Sticky status: a new event wins over the clear by read.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      status_r <= 2'h0;
      reqPrev_r <= 1'b0;
      lastVec_r <= 8'h00;
    end else if (ce) begin
      status_r <= (rdClr ? 2'h0 : status_r) | events;
      reqPrev_r <= link.intReq;
      if (link.vecValid) begin
        lastVec_r <= link.vecData;
      end
    end
  end

  // Level interrupt from unmasked status, registered.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_r <= 1'b0;
    end else if (ce) begin
      irq_r <= |(status_r & mask_r);
    end
  end
endmodule // ctu_host

// ---- dv/ctu_assertions.sv ----
/*
  Checker on the link between controller and channel.
  Assumes one clock domain and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module ctu_assertions #(
  parameter int CHAN_NUM = 2
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic wrStb,
  input wire logic [7:0] wrData,
  input wire logic intAck,
  input wire logic pinRoute,
  input wire logic intReq,
  input wire logic vecValid,
  input wire logic [7:0] vecData
);
  // One domain, so clock and reset are stated once for all properties.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // An acknowledged request answers with a vector one cycle later.
  chk_vec_after_ack: assert property (intAck && intReq |=> vecValid)
    else $error("no vector after acknowledge");
  chk_vec_has_cause: assert property (
    vecValid |-> $past(intAck) && $past(intReq))
    else $error("vector without acknowledge");
  // The filled bits carry the channel number and bit zero stays clear.
  chk_vec_chan_bits: assert property (
    vecValid |-> vecData[2:1] == 2'(CHAN_NUM) && !vecData[0])
    else $error("vector low bits wrong");
  chk_vec_held: assert property (!vecValid |-> $stable(vecData))
    else $error("vector changed without acknowledge");
  chk_vec_single: assert property (vecValid |=> !vecValid)
    else $error("vector valid longer than one cycle");
  // A request only drops after an acknowledge or a software reset byte.
  chk_req_fall_cause: assert property (
    $fell(intReq) |-> $past(intAck) || ($past(wrStb) && $past(wrData[1])))
    else $error("request dropped without cause");
  // With neither acknowledge nor byte, a pending request must stay.
  chk_req_held: assert property (
    intReq && !intAck && !wrStb |=> intReq)
    else $error("request dropped while pending");
  // Each byte is one strobe, so the channel never sees it twice.
  chk_stb_pulse: assert property (wrStb |=> !wrStb)
    else $error("write strobe longer than one cycle");
  chk_ack_pulse: assert property (intAck |=> !intAck ##1 !intAck)
    else $error("acknowledge repeated");
endmodule // ctu_assertions

// ---- dv/ctu_tb_top.sv ----
/*
  Testbench: APB controller and channel joined by the link interface.
  Assumes one 100 MHz clock; all inputs change just after rising edges.
*/
`timescale 1ns/1ps
`include "ctu_consts.svh"
module counter_timer_channel_programming_tb_top;
  logic mclk, nrst, psel, penable, pwrite, trigPin, pioTrig, pready;
  logic pslverr, irq, zcOut, pioOut, err, ce;
  logic [7:0] paddr, countVal;
  logic [31:0] pwdata, prdata, rdv;
  int n_mismatch = 0;
  int total_checks = 0;
  int n;
  ctu_link_if lnk();
  ctu_host ctu_host_i(.mclk(mclk), .nrst(nrst), .ce(ce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .link(lnk.host));
  ctu_channel ctu_channel_i(.mclk(mclk), .nrst(nrst), .ce(ce),
    .link(lnk.dev), .chanNum(2'h2), .trigPin(trigPin), .pioTrig(pioTrig),
    .zcOut(zcOut), .pioOut(pioOut), .countVal(countVal));
  ctu_assertions #(.CHAN_NUM(2)) ctu_assertions_i(.mclk(mclk),
    .nrst(nrst), .wrStb(lnk.wrStb), .wrData(lnk.wrData),
    .intAck(lnk.intAck), .pinRoute(lnk.pinRoute), .intReq(lnk.intReq),
    .vecValid(lnk.vecValid), .vecData(lnk.vecData));

  // Verdict and end of run, also reached when a wait runs out.
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hang(input string nm);
    n_mismatch++;
    $display("Error %s expected answer seen timeout", nm);
    wrap_up();
  endtask
  // One APB transfer; the answer is taken at the rising edge at which
  // pready is seen high, and only then is the request released.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    if (pready !== 1'h1) hang("pready");
    rdv = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'h1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    apb(1'h0, a, 32'h0);
    chk(nm, e, rdv);
  endtask
  task automatic idle(input int c);
    repeat (c) @(negedge mclk);
  endtask
  task automatic pin(input logic v);
    @(posedge mclk);
    trigPin <= v;
  endtask
  // Counts cycles up to the next zero-count pulse.
  task automatic wait_zc(input int lim);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (zcOut !== 1'h1 && n < lim);
    if (zcOut !== 1'h1) hang("zero count");
  endtask
  // The count must neither move nor reach zero for c cycles.
  task automatic quiet(input int c, input string nm);
    logic [7:0] v;
    int bad;
    bad = 0;
    // Let the byte just written reach the channel before the snapshot.
    repeat (2) @(negedge mclk);
    v = countVal;
    repeat (c) begin
      @(negedge mclk);
      if (zcOut !== 1'h0 || countVal !== v) bad++;
    end
    chk(nm, 0, bad);
  endtask

  // Clock of 10 ns.
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  // A hang anywhere ends in the same verdict.
  initial begin
    #400us;
    hang("watchdog");
  end
  // Main sequence.
  initial begin
    {nrst, psel, penable, pwrite, trigPin, pioTrig} = 6'h0;
    paddr = 8'h0;
    ce = 1'h1;
    pwdata = 32'h0;
    repeat (6) @(posedge mclk);
    nrst <= 1'h1;
    rd(`CTU_OFF_SETUP, 32'h0, "setup reset");
    rd(`CTU_OFF_MASK, 32'h0, "mask reset");
    rd(8'h20, 32'h0, "unmapped read");
    chk("unmapped error", 1'h1, err);
    $display("Test registers finished");
    wr(`CTU_OFF_WORD, 8'hA8);
    wr(`CTU_OFF_WORD, 8'h85);
    quiet(40, "idle before constant");
    wr(`CTU_OFF_WORD, 8'h03);
    idle(2);
    chk("loaded count", 8'h03, countVal);
    wait_zc(100);
    wait_zc(100);
    chk("divide by 16 period", 48, n);
    chk("irq masked", 1'h0, irq);
    wr(`CTU_OFF_MASK, 8'h01);
    idle(2);
    chk("irq raised", 1'h1, irq);
    wr(`CTU_OFF_ACK, 8'h00);
    idle(3);
    rd(`CTU_OFF_VEC, 32'hAC, "vector");
    rd(`CTU_OFF_STAT, 32'h3, "status");
    rd(`CTU_OFF_STAT, 32'h0, "status cleared");
    idle(2);
    chk("irq cleared", 1'h0, irq);
    wr(`CTU_OFF_WORD, 8'h01);
    wait_zc(60);
    idle(2);
    chk("no request when disabled", 1'h0, lnk.intReq);
    $display("Test timer finished");
    wr(`CTU_OFF_WORD, 8'h25);
    wr(`CTU_OFF_WORD, 8'h01);
    wait_zc(800);
    wait_zc(300);
    chk("divide by 256 period", 256, n);
    wr(`CTU_OFF_WORD, 8'h03);
    quiet(300, "stopped by reset");
    wr(`CTU_OFF_WORD, 8'h57);
    pin(1'h1);
    quiet(10, "edge before constant");
    pin(1'h0);
    wr(`CTU_OFF_WORD, 8'h09);
    idle(2);
    chk("constant after announce", 8'h09, countVal);
    for (int s = 0; s < 2; s++) begin
      wr(`CTU_OFF_WORD, 8'h47 | 8'(s << 4));
      wr(`CTU_OFF_WORD, 8'h05);
      pin(1'h1);
      idle(3);
      chk("count after rise", s ? 8'h04 : 8'h05, countVal);
      pin(1'h0);
      idle(3);
      chk("count after fall", 8'h04, countVal);
    end
    wr(`CTU_OFF_WORD, 8'h57);
    wr(`CTU_OFF_WORD, 8'h00);
    repeat (255) begin
      pin(1'h1);
      pin(1'h0);
    end
    idle(3);
    chk("zero loads 256", 8'h01, countVal);
    pin(1'h1);
    wait_zc(6);
    pin(1'h0);
    $display("Test counter finished");
    wr(`CTU_OFF_WORD, 8'h1F);
    wr(`CTU_OFF_WORD, 8'h01);
    quiet(40, "waits for trigger");
    pin(1'h1);
    wait_zc(40);
    chk("trigger to zero", 1'h1, n >= 16 && n <= 22);
    // A low clock enable must freeze the running timer completely.
    @(posedge mclk);
    ce <= 1'h0;
    quiet(40, "frozen by enable");
    @(posedge mclk);
    ce <= 1'h1;
    wr(`CTU_OFF_WORD, 8'h03);
    pin(1'h0);
    wr(`CTU_OFF_SETUP, 8'h01);
    rd(`CTU_OFF_SETUP, 32'h1, "setup readback");
    chk("pins routed", 1'h1, lnk.pinRoute);
    wr(`CTU_OFF_WORD, 8'h57);
    wr(`CTU_OFF_WORD, 8'h03);
    pin(1'h1);
    idle(3);
    chk("own pin ignored", 8'h03, countVal);
    @(posedge mclk);
    pioTrig <= 1'h1;
    idle(3);
    chk("port pin counts", 8'h02, countVal);
    // Two more port pin edges reach zero, which the port output shows.
    repeat (2) begin
      @(posedge mclk);
      pioTrig <= 1'h0;
      @(posedge mclk);
      pioTrig <= 1'h1;
    end
    idle(2);
    chk("port pin pulse", 1'h1, pioOut);
    $display("Test routing finished");
    wrap_up();
  end
endmodule // counter_timer_channel_programming_tb_top
